// >>> verilog/fam_pkg.sv
// Shared constants for the flash address-space decoder
package fam_pkg;
  // Instruction codes
  localparam logic [7:0] CMD_READ3     = 8'h03;
  localparam logic [7:0] CMD_READ4     = 8'h13;
  localparam logic [7:0] CMD_RD_ID     = 8'h9f;
  localparam logic [7:0] CMD_RD_PARAMS = 8'h5a;
  localparam logic [7:0] CMD_SEC_READ  = 8'h48;
  localparam logic [7:0] CMD_SEC_PROG  = 8'h42;
  localparam logic [7:0] CMD_SEC_ERASE = 8'h44;
  localparam logic [7:0] CMD_SECT_ER   = 8'h20;
  localparam logic [7:0] CMD_HALF_ER   = 8'h52;
  localparam logic [7:0] CMD_BLOCK_ER  = 8'hd8;
  localparam logic [7:0] CMD_EXT_ON    = 8'hb7;
  localparam logic [7:0] CMD_EXT_OFF   = 8'he9;

  // Address widths in bytes, last byte index
  localparam logic [2:0] LAST_ADDR3 = 3'd2;
  localparam logic [2:0] LAST_ADDR4 = 3'd3;
  localparam logic [2:0] LAST_BIT   = 3'd7;

  // Erase unit masks (4 KB, 32 KB, 64 KB)
  localparam logic [31:0] SECT_MASK  = 32'h0000_0fff;
  localparam logic [31:0] HALF_MASK  = 32'h0000_7fff;
  localparam logic [31:0] BLOCK_MASK = 32'h0000_ffff;
  localparam logic [31:0] ADDR24_MASK = 32'h00ff_ffff;

  // Security space: 4 regions of 256 bytes
  localparam int         SEC_AW       = 10;
  localparam int         REG_AW       = 8;
  localparam logic [1:0] REGION_TEMP  = 2'd2;
  localparam logic [1:0] REGION_RDPR  = 2'd3;
  localparam logic [7:0] ERASED_BYTE  = 8'hff;
  localparam logic [7:0] INVALID_BYTE = 8'h00;

  // Parameter space layout
  localparam logic [31:0] SIG_WORD    = 32'h5346_4450;
  localparam logic [3:0]  PARAM_ID_HI = 4'h1;
  localparam logic [3:0]  ID_UID_OFS  = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPC  = 2'b01,
    ST_ADDR = 2'b11,
    ST_DATA = 2'b10
  } fam_state_e;

  typedef enum logic [1:0] {
    ER_SECT  = 2'd0,
    ER_HALF  = 2'd1,
    ER_BLOCK = 2'd2
  } fam_erase_e;
endpackage

// >>> verilog/fam_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module fam_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d_i ^ rst_val_i;
      q_reg    <= meta_reg;
    end
  end

  // Flops hold data relative to the reset value, so reset takes constants
  assign q_o = q_reg ^ rst_val_i;
endmodule

// >>> verilog/fam_sec_mem.sv
// Security region storage, 1024 bytes in flip-flops
`timescale 1ns/10ps
module fam_sec_mem
  import fam_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wr_en_i,
  input  wire logic [SEC_AW-1:0] wr_idx_i,
  input  wire logic [7:0]        wr_data_i,
  input  wire logic              er_en_i,
  input  wire logic [1:0]        er_region_i,
  input  wire logic [SEC_AW-1:0] rd_idx_i,
  output logic      [7:0]        rd_data_o
);
  localparam int DEPTH = 1 << SEC_AW;
  logic [7:0] mem_reg  [DEPTH];
  logic [7:0] mem_next [DEPTH];

  always_comb begin
    mem_next = mem_reg;
    // Programming only clears bits, as on flash
    if (wr_en_i) begin
      mem_next[wr_idx_i] = mem_reg[wr_idx_i] & wr_data_i;
    end
    if (er_en_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (i[SEC_AW-1:REG_AW] == er_region_i) begin
          mem_next[i] = ERASED_BYTE;
        end
      end
    end
  end

  // erased delivery state
  // Delivered state is all bytes erased
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= ERASED_BYTE;
      end
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign rd_data_o = mem_reg[rd_idx_i];
endmodule

// >>> verilog/fam_addr_map.sv
// Serial command decoder with address-space map and region protection
// Summary of operation
// - Legacy commands take a 24-bit address unless extended mode is on.
// - Volatile extended mode makes legacy commands take 32-bit addresses.
// - Dedicated four-byte commands always take a 32-bit address.
// - Reset loads extended mode from the non-volatile default bit.
// - 24-bit addressing reaches 16 MB; 32-bit reaches 4 GB.
// - Parameter and security spaces use full address width, decode all bits; bytes above their range read FFh.
// - Main array erases 64 KB, 32 KB, 4 KB units, size-aligned.
// - Code 9Fh reads a separate read-only identification space.
// - Identification space holds an 8-byte unique device number.
// - Code 5Ah reads the read-only discoverable-parameter space.
// - Identification bytes also appear as a parameter table.
// - A separate 1024-byte security space supports program, erase, read.
// - Security space is four 256-byte lockable regions.
// - Security bytes read FFh when erased as delivered.
// - Unlocked regions program like flash; erase clears one region.
// - One-time lock bits permanently block program/erase per region.
// - Temporary lock blocks program/erase of regions 2 and 3.
// - Password protection blocks program/erase of regions 2 and 3 until password given.
// - Read protection blocks reads of region 3 until password given.
// - Reads of read-protected region return invalid data.
// - Blocked program/erase changes nothing and sets error flag.
`timescale 1ns/10ps
module fam_addr_map
  import fam_pkg::*;
#(
  parameter logic [63:0] DEVICE_ID = 64'h0102_0304_0506_0708, // Arbitrary
  parameter logic [63:0] UNIQUE_ID = 64'h1122_3344_5566_7788  // Arbitrary
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 soft_rst_i,
  input  wire logic                 cs_n_i,
  input  wire logic                 sck_i,
  input  wire logic                 si_i,
  output logic                      so_o,
  output logic                      so_oe_o,
  input  wire logic                 ext_addr_nv_i,
  input  wire logic [3:0]           otp_lock_i,
  input  wire logic                 temp_region_lock_i,
  input  wire logic                 pwd_prot_i,
  input  wire logic                 read_prot_i,
  input  wire logic                 pwd_ok_i,
  input  wire logic                 clr_status_i,
  input  wire logic [7:0]           array_rdata_i,
  output logic [31:0]               array_addr_o,
  output logic                      array_erase_o,
  output fam_pkg::fam_erase_e       array_erase_kind_o,
  output logic [31:0]               array_erase_addr_o,
  output logic                      ext_addr_o,
  output logic                      prog_err_o,
  output logic                      erase_err_o
);
  import fam_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic wr_blocked(input logic [1:0] rgn);
    logic hi;
    hi = (rgn >= REGION_TEMP);
    // Protection checks: lock, temporary lock, password
    // one-time lock
    return otp_lock_i[rgn] | (hi & temp_region_lock_i)
           | (hi & pwd_prot_i & ~pwd_ok_i);
  endfunction

  function automatic logic rd_blocked(input logic [1:0] rgn);
    return (rgn == REGION_RDPR) & read_prot_i & ~pwd_ok_i;
  endfunction

  function automatic logic [7:0] id_byte(input logic [3:0] idx);
    logic [2:0] b;
    b = 3'd7 - idx[2:0];
    if (idx >= ID_UID_OFS) begin
      return UNIQUE_ID[8*b +: 8];
    end
    return DEVICE_ID[8*b +: 8];
  endfunction

  function automatic logic uses_addr(input logic [7:0] op);
    return op inside {CMD_READ3, CMD_READ4, CMD_RD_PARAMS, CMD_SEC_READ,
                      CMD_SEC_PROG, CMD_SEC_ERASE, CMD_SECT_ER,
                      CMD_HALF_ER, CMD_BLOCK_ER};
  endfunction

  function automatic logic drives_out(input logic [7:0] op);
    return op inside {CMD_READ3, CMD_READ4, CMD_RD_ID, CMD_RD_PARAMS,
                      CMD_SEC_READ};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [2:0] pins_s;
  logic       cs_s;
  logic       sck_s;
  logic       si_s;

  fam_sync #(.W(3)) u_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .d_i       ({cs_n_i, sck_i, si_i}),
    .rst_val_i (3'b100),
    .q_o       (pins_s)
  );
  assign {cs_s, sck_s, si_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // State
  fam_state_e  state_reg,  state_next;
  logic [7:0]  op_reg,     op_next;
  logic [2:0]  bit_reg,    bit_next;
  logic [2:0]  obit_reg,   obit_next;
  logic [2:0]  abyte_reg,  abyte_next;
  logic [7:0]  rx_reg,     rx_next;
  logic [7:0]  tx_reg,     tx_next;
  logic [31:0] addr_reg,   addr_next;
  logic        so_reg,     so_next;
  logic        oe_reg,     oe_next;
  logic        ext_reg,    ext_next;
  logic        loaded_reg, loaded_next;
  logic        perr_reg,   perr_next;
  logic        eerr_reg,   eerr_next;
  logic        er_reg,     er_next;
  fam_erase_e  kind_reg,   kind_next;
  logic [31:0] eaddr_reg,  eaddr_next;
  logic        sck_q_reg,  cs_q_reg;

  logic              sck_rise, sck_fall, cs_rise, byte_in;
  logic [7:0]        rx_byte, fetch;
  logic [2:0]        last_abyte;
  logic [1:0]        rgn;
  logic              perr_set, eerr_set, load_fire;
  logic              sec_wr, sec_er;
  logic [7:0]        sec_rd;

  assign sck_rise = sck_s & ~sck_q_reg & ~cs_s;
  assign sck_fall = ~sck_s & sck_q_reg & ~cs_s;
  assign cs_rise  = cs_s & ~cs_q_reg;
  assign rx_byte  = {rx_reg[6:0], si_s};
  assign byte_in  = sck_rise & (bit_reg == LAST_BIT);
  assign rgn      = addr_reg[SEC_AW-1:REG_AW];
  // Only reads load the shifter, so a program keeps its byte address
  assign load_fire = sck_fall & (state_reg == ST_DATA) & (obit_reg == '0)
                     & drives_out(op_reg);

  assign last_abyte = (op_reg == CMD_READ4 || ext_reg) ? LAST_ADDR4
                                                        : LAST_ADDR3;

  fam_sec_mem u_mem (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .wr_en_i     (sec_wr),
    .wr_idx_i    (addr_reg[SEC_AW-1:0]),
    .wr_data_i   (rx_byte),
    .er_en_i     (sec_er),
    .er_region_i (rgn),
    .rd_idx_i    (addr_reg[SEC_AW-1:0]),
    .rd_data_o   (sec_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection per address space
  always_comb begin
    fetch = ERASED_BYTE;
    case (op_reg)
      CMD_READ3, CMD_READ4: fetch = array_rdata_i;
      CMD_RD_ID: fetch = id_byte(addr_reg[3:0]);
      CMD_RD_PARAMS: begin
        if (addr_reg[31:8] != '0) begin
          fetch = ERASED_BYTE;
        end else if (addr_reg[7:2] == '0) begin
          fetch = SIG_WORD[8*(3-addr_reg[1:0]) +: 8];
        end else if (addr_reg[7:4] == PARAM_ID_HI) begin
          fetch = id_byte(addr_reg[3:0]);
        end
      end
      CMD_SEC_READ: begin
        if (addr_reg[31:SEC_AW] != '0) begin
          fetch = ERASED_BYTE;
        end else if (rd_blocked(rgn)) begin
          fetch = INVALID_BYTE;
        end else begin
          fetch = sec_rd;
        end
      end
      default: fetch = ERASED_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencing
  always_comb begin
    state_next  = state_reg;
    op_next     = op_reg;
    bit_next    = bit_reg;
    obit_next   = obit_reg;
    abyte_next  = abyte_reg;
    rx_next     = rx_reg;
    tx_next     = tx_reg;
    addr_next   = addr_reg;
    so_next     = so_reg;
    ext_next    = ext_reg;
    loaded_next = 1'b1;
    er_next     = 1'b0;
    kind_next   = kind_reg;
    eaddr_next  = eaddr_reg;
    perr_set    = 1'b0;
    eerr_set    = 1'b0;
    sec_wr      = 1'b0;
    sec_er      = 1'b0;

    if (!loaded_reg || soft_rst_i) begin
      ext_next = ext_addr_nv_i;
    end

    if (sck_rise) begin
      rx_next  = rx_byte;
      bit_next = bit_reg + 3'd1;
    end

    case (state_reg)
      ST_IDLE: begin
        if (!cs_s) begin
          state_next = ST_OPC;
          bit_next   = '0;
          obit_next  = '0;
          abyte_next = '0;
          addr_next  = '0;
        end
      end
      ST_OPC: begin
        if (byte_in) begin
          op_next    = rx_byte;
          state_next = uses_addr(rx_byte) ? ST_ADDR : ST_DATA;
        end
      end
      ST_ADDR: begin
        if (sck_rise) begin
          addr_next = {addr_reg[30:0], si_s};
        end
        if (byte_in) begin
          abyte_next = abyte_reg + 3'd1;
          if (abyte_reg == last_abyte) begin
            state_next = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (load_fire) begin
          so_next   = fetch[7];
          tx_next   = {fetch[6:0], 1'b0};
          // 24-bit mode wraps within 16 MB
          addr_next = ext_reg || op_reg == CMD_READ4 ? addr_reg + 32'd1
                      : (addr_reg + 32'd1) & ADDR24_MASK;
        end else if (sck_fall) begin
          so_next = tx_reg[7];
          tx_next = {tx_reg[6:0], 1'b0};
        end
        if (sck_fall) begin
          obit_next = obit_reg + 3'd1;
        end
        if (byte_in && op_reg == CMD_SEC_PROG &&
            addr_reg[31:SEC_AW] == '0) begin
          if (wr_blocked(rgn)) begin
            perr_set = 1'b1;
          end else begin
            sec_wr = 1'b1;
          end
          addr_next = {addr_reg[31:REG_AW], addr_reg[REG_AW-1:0] + 8'd1};
        end
        // Commands executing at deselect, on a byte boundary only
        if (cs_rise && bit_reg == '0) begin
          case (op_reg)
            CMD_EXT_ON:  ext_next = 1'b1;
            CMD_EXT_OFF: ext_next = 1'b0;
            CMD_SEC_ERASE: begin
              if (addr_reg[31:SEC_AW] != '0) begin
                sec_er = 1'b0;
              end else if (wr_blocked(rgn)) begin
                eerr_set = 1'b1;
              end else begin
                sec_er = 1'b1;
              end
            end
            CMD_SECT_ER: begin
              er_next    = 1'b1;
              kind_next  = ER_SECT;
              eaddr_next = addr_reg & ~SECT_MASK;
            end
            CMD_HALF_ER: begin
              er_next    = 1'b1;
              kind_next  = ER_HALF;
              eaddr_next = addr_reg & ~HALF_MASK;
            end
            CMD_BLOCK_ER: begin
              er_next    = 1'b1;
              kind_next  = ER_BLOCK;
              eaddr_next = addr_reg & ~BLOCK_MASK;
            end
            default: ;
          endcase
        end
      end
      default: state_next = ST_IDLE;
    endcase

    if (cs_s) begin
      state_next = ST_IDLE;
    end
    oe_next = (state_next == ST_DATA) && drives_out(op_next);
    // Set wins over a clear in the same cycle
    perr_next = perr_set | (perr_reg & ~clr_status_i);
    eerr_next = eerr_set | (eerr_reg & ~clr_status_i);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg  <= ST_IDLE;
      op_reg     <= '0;
      bit_reg    <= '0;
      obit_reg   <= '0;
      abyte_reg  <= '0;
      rx_reg     <= '0;
      tx_reg     <= '0;
      addr_reg   <= '0;
      so_reg     <= 1'b0;
      oe_reg     <= 1'b0;
      ext_reg    <= 1'b0;
      loaded_reg <= 1'b0;
      perr_reg   <= 1'b0;
      eerr_reg   <= 1'b0;
      er_reg     <= 1'b0;
      kind_reg   <= ER_SECT;
      eaddr_reg  <= '0;
      sck_q_reg  <= 1'b0;
      cs_q_reg   <= 1'b1;
    end else begin
      state_reg  <= state_next;
      op_reg     <= op_next;
      bit_reg    <= bit_next;
      obit_reg   <= obit_next;
      abyte_reg  <= abyte_next;
      rx_reg     <= rx_next;
      tx_reg     <= tx_next;
      addr_reg   <= addr_next;
      so_reg     <= so_next;
      oe_reg     <= oe_next;
      ext_reg    <= ext_next;
      loaded_reg <= loaded_next;
      perr_reg   <= perr_next;
      eerr_reg   <= eerr_next;
      er_reg     <= er_next;
      kind_reg   <= kind_next;
      eaddr_reg  <= eaddr_next;
      sck_q_reg  <= sck_s;
      cs_q_reg   <= cs_s;
    end
  end

  assign so_o               = so_reg;
  assign so_oe_o            = oe_reg;
  assign array_addr_o       = addr_reg;
  assign array_erase_o      = er_reg;
  assign array_erase_kind_o = kind_reg;
  assign array_erase_addr_o = eaddr_reg;
  assign ext_addr_o         = ext_reg;
  assign prog_err_o         = perr_reg;
  assign erase_err_o        = eerr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_addr_done;
    state_reg == ST_ADDR && state_next == ST_DATA;
  endsequence

  a_reset_mode: assert property (
    $rose(loaded_reg) |-> ext_reg == $past(ext_addr_nv_i))
    else $error("mode not loaded from default");
  a_four_byte: assert property (
    s_addr_done ##0 (op_reg == CMD_READ4) |-> abyte_reg == LAST_ADDR4)
    else $error("four-byte command took wrong width");
  a_legacy_width: assert property (
    s_addr_done ##0 (op_reg == CMD_READ3 && !ext_reg)
      |-> abyte_reg == LAST_ADDR3 ##1 addr_reg[31:24] == '0)
    else $error("legacy address width wrong");
  a_otp_lock: assert property (
    sec_wr || sec_er |-> !otp_lock_i[rgn])
    else $error("write into locked region");
  a_temp_lock: assert property (
    (sec_wr || sec_er) && temp_region_lock_i |-> rgn < REGION_TEMP)
    else $error("write into temporarily locked region");
  a_pwd_gate: assert property (
    (sec_wr || sec_er) && pwd_prot_i && !pwd_ok_i |-> rgn < REGION_TEMP)
    else $error("write into password protected region");
  a_read_prot: assert property (
    load_fire && op_reg == CMD_SEC_READ && rd_blocked(rgn)
      && addr_reg[31:SEC_AW] == '0 |=> so_reg == INVALID_BYTE[7])
    else $error("protected region data leaked");
  a_err_flag: assert property (
    state_reg == ST_DATA && byte_in && op_reg == CMD_SEC_PROG
      && addr_reg[31:SEC_AW] == '0 && wr_blocked(rgn)
      |-> !sec_wr ##1 perr_reg)
    else $error("program error not flagged");
  a_err_sticky: assert property (
    eerr_reg && !clr_status_i |=> eerr_reg)
    else $error("erase error flag lost");
  a_erase_align: assert property (
    er_reg |-> (kind_reg != ER_SECT  || (eaddr_reg & SECT_MASK) == '0)
            && (kind_reg != ER_HALF  || (eaddr_reg & HALF_MASK) == '0)
            && (kind_reg != ER_BLOCK || (eaddr_reg & BLOCK_MASK) == '0))
    else $error("erase address not aligned");
endmodule

// >>> tb/fam_spi_host.sv
// Host controller model that clocks flash commands over the serial pins
`timescale 1ns/10ps
module fam_spi_host (
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  localparam real HALF = 24.0;

  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end

  // One bit: falling edge, drive, sample just before the rise
  task automatic bit_xfer(input logic b, output logic r);
    sck_o = 1'b0;
    si_o  = b;
    #HALF;
    r     = so_oe_i ? so_i : 1'bz;
    sck_o = 1'b1;
    #HALF;
  endtask

  // Opcode, address bytes, program bytes, then read bytes; clock idles low
  task automatic xfer(input logic [7:0] op, input logic [31:0] adr,
                      input int nab, input logic [7:0] wd, input int nw,
                      input int nr, output logic [127:0] rd);
    logic r;
    cs_n_o = 1'b0;
    #HALF;
    for (int i = 7; i >= 0; i--) bit_xfer(op[i], r);
    for (int i = nab * 8 - 1; i >= 0; i--) bit_xfer(adr[i], r);
    for (int i = nw * 8 - 1; i >= 0; i--) bit_xfer(wd[i % 8], r);
    rd = '0;
    for (int i = 0; i < nr * 8; i++) begin
      bit_xfer(~si_o, r);
      rd = {rd[126:0], r};
    end
    sck_o = 1'b0;
    #HALF;
    cs_n_o = 1'b1;
    si_o   = ~si_o;
    #(4 * HALF);
  endtask
endmodule

// >>> tb/tb_fam_addr_map.sv
// Self-checking bench for the flash address-space decoder
`timescale 1ns/10ps
module tb_fam_addr_map;
  import fam_pkg::*;
  localparam logic [63:0] DEV_ID = 64'ha1b2_c3d4_e5f6_0718; // Arbitrary
  localparam logic [63:0] UNQ_ID = 64'h0f1e_2d3c_4b5a_6978; // Arbitrary
  logic         clk_i, rst_i, soft_rst, cs_n, sck, si, so, so_oe, ext_nv;
  logic [3:0]   otp_lock;
  logic         temp_lock, pwd_prot, read_prot, pwd_ok, clr_status;
  logic [7:0]   array_rdata;
  logic [31:0]  array_addr, erase_addr, er_addr;
  logic         array_erase, ext_addr, prog_err, erase_err;
  fam_erase_e   erase_kind, er_kind;
  logic [127:0] rd;
  int           mismatches = 0, cmp_count = 0, er_cnt = 0, n;
  logic [7:0]   eop [3] = '{CMD_SECT_ER, CMD_HALF_ER, CMD_BLOCK_ER};
  logic [31:0]  msk [3] = '{SECT_MASK, HALF_MASK, BLOCK_MASK};

  fam_spi_host u_fam_spi_host (.cs_n_o(cs_n), .sck_o(sck), .si_o(si),
                               .so_i(so), .so_oe_i(so_oe));
  fam_addr_map #(.DEVICE_ID(DEV_ID), .UNIQUE_ID(UNQ_ID)) u_fam_addr_map (
    .clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst), .cs_n_i(cs_n),
    .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe),
    .ext_addr_nv_i(ext_nv), .otp_lock_i(otp_lock),
    .temp_region_lock_i(temp_lock), .pwd_prot_i(pwd_prot),
    .read_prot_i(read_prot), .pwd_ok_i(pwd_ok), .clr_status_i(clr_status),
    .array_rdata_i(array_rdata), .array_addr_o(array_addr),
    .array_erase_o(array_erase), .array_erase_kind_o(erase_kind),
    .array_erase_addr_o(erase_addr), .ext_addr_o(ext_addr),
    .prog_err_o(prog_err), .erase_err_o(erase_err));

  // Main array content is a simple function of the address
  assign array_rdata = array_addr[7:0] ^ 8'h5a;

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
    if (array_erase === 1'b1) begin
      er_cnt  <= er_cnt + 1;
      er_kind <= erase_kind;
      er_addr <= erase_addr;
    end

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [127:0] exp,
                     input logic [127:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic step;
    @(posedge clk_i);
    #1;
  endtask

  task automatic cmd(input logic [7:0] op, input logic [31:0] a,
                     input int nab, input logic [7:0] wd, input int nw,
                     input int nr);
    u_fam_spi_host.xfer(op, a, nab, wd, nw, nr, rd);
  endtask

  // Locked region refuses program and erase; region r^2 still accepts a program
  task automatic blocked(input logic [1:0] r, input logic [3:0] otp,
                         input logic tl, input logic pp);
    logic [31:0] a;
    a = {22'h0, r, 8'h40};
    cmd(CMD_SEC_PROG, a, 3, 8'h81, 1, 0);
    step;
    {otp_lock, temp_lock, pwd_prot} = {otp, tl, pp};
    cmd(CMD_SEC_PROG, a ^ 32'h220, 3, 8'h7e, 1, 0);
    chk("prog_err_other", 1'b0, prog_err);
    cmd(CMD_SEC_PROG, a, 3, 8'h00, 1, 0);
    chk("prog_err", 2'b10, {prog_err, erase_err});
    cmd(CMD_SEC_ERASE, a, 3, 0, 0, 0);
    chk("erase_err", 1'b1, erase_err);
    cmd(CMD_SEC_READ, a, 3, 0, 0, 1);
    chk("locked_byte", 8'h81, rd);
    step;
    {otp_lock, temp_lock, pwd_prot, clr_status} = 7'h01;
    step;
    clr_status = 1'b0;
    step;
    chk("err_clear", 2'b00, {prog_err, erase_err});
    cmd(CMD_SEC_ERASE, a, 3, 0, 0, 0);
  endtask

  task automatic print_verdict;
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #400us;
    mismatches++;
    print_verdict;
  end

  initial begin
    {rst_i, soft_rst, ext_nv, otp_lock, temp_lock} = 8'h80;
    {pwd_prot, read_prot, pwd_ok, clr_status} = 4'h0;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (4) step;
    chk("ext_reset", 1'b0, ext_addr);
    cmd(CMD_RD_ID, 0, 0, 0, 0, 16);
    chk("id_space", {DEV_ID, UNQ_ID}, rd);
    cmd(CMD_RD_PARAMS, 0, 3, 0, 0, 4);
    chk("param_sig", SIG_WORD, rd);
    cmd(CMD_RD_PARAMS, 32'h10, 3, 0, 0, 16);
    chk("param_id", {DEV_ID, UNQ_ID}, rd);
    cmd(CMD_SEC_READ, 32'h3fe, 3, 0, 0, 2);
    chk("sec_erased", 16'hffff, rd);
    cmd(CMD_SEC_PROG, 32'h105, 3, 8'ha5, 2, 0);
    cmd(CMD_SEC_PROG, 32'h105, 3, 8'h3c, 1, 0);
    cmd(CMD_SEC_PROG, 32'h010, 3, 8'h00, 1, 0);
    cmd(CMD_SEC_READ, 32'h105, 3, 0, 0, 2);
    chk("sec_prog", 16'h24a5, rd);
    cmd(CMD_SEC_ERASE, 32'h1c0, 3, 0, 0, 0);
    cmd(CMD_SEC_READ, 32'h105, 3, 0, 0, 2);
    chk("sec_erase", 16'hffff, rd);
    cmd(CMD_SEC_READ, 32'h010, 3, 0, 0, 1);
    chk("sec_other", 8'h00, rd);
    for (int k = 0; k < 4; k++) blocked(2'(k), 4'b0001 << k, 0, 0);
    blocked(2'd2, 4'h0, 1'b1, 1'b0);
    blocked(2'd3, 4'h0, 1'b0, 1'b1);
    step;
    {pwd_prot, pwd_ok} = 2'b11;
    cmd(CMD_SEC_PROG, 32'h300, 3, 8'h5a, 1, 0);
    chk("pwd_lifted", 1'b0, prog_err);
    step;
    {read_prot, pwd_ok} = 2'b10;
    cmd(CMD_SEC_READ, 32'h300, 3, 0, 0, 1);
    chk("rd_prot", INVALID_BYTE, rd);
    cmd(CMD_SEC_READ, 32'h2ff, 3, 0, 0, 1);
    chk("rd_prot_r2", 8'hff, rd);
    step;
    pwd_ok = 1'b1;
    cmd(CMD_SEC_READ, 32'h300, 3, 0, 0, 1);
    chk("rd_pwd_ok", 8'h5a, rd);
    step;
    {pwd_prot, read_prot, pwd_ok, ext_nv, rst_i} = 5'h03;
    repeat (2) step;
    rst_i = 1'b0;
    repeat (4) step;
    chk("ext_rst_nv", 1'b1, ext_addr);
    cmd(CMD_READ3, 32'h8765_4321, 4, 0, 0, 2);
    chk("rd32_data", 16'h7b78, rd);
    chk("rd32_addr", 24'h876543, array_addr[31:8]);
    cmd(CMD_SEC_READ, 32'h300, 4, 0, 0, 2);
    chk("sec_ext", 16'hffff, rd);
    step;
    {ext_nv, soft_rst} = 2'b01;
    step;
    soft_rst = 1'b0;
    repeat (2) step;
    chk("ext_soft", 1'b0, ext_addr);
    cmd(CMD_EXT_ON, 0, 0, 0, 0, 0);
    chk("ext_on", 1'b1, ext_addr);
    cmd(CMD_EXT_OFF, 0, 0, 0, 0, 0);
    chk("ext_off", 1'b0, ext_addr);
    cmd(CMD_READ4, 32'h1234_56f0, 4, 0, 0, 2);
    chk("rd4_data", 16'haaab, rd);
    chk("rd4_addr", 24'h123456, array_addr[31:8]);
    cmd(CMD_READ3, 32'hff_fffe, 3, 0, 0, 3);
    chk("rd24_wrap", 24'ha4a55a, rd);
    chk("rd24_high", 8'h00, array_addr[31:24]);
    for (int k = 0; k < 3; k++) begin
      n = er_cnt;
      cmd(eop[k], 32'hab_cdef, 3, 0, 0, 0);
      chk("erase_pulse", n + 1, er_cnt);
      chk("erase_kind", k, er_kind);
      chk("erase_addr", 32'hab_cdef & ~msk[k], er_addr);
    end
    print_verdict;
  end
endmodule
